// ===== shared/shp_consts.svh
// Purpose: constants of the serial controller host port
// Assumes: 25 MHz clk, synchronous active-low reset
`ifndef SHP_CONSTS_SVH
`define SHP_CONSTS_SVH
`define SHP_TX_DEPTH     2
`define SHP_RX_DEPTH     4
`define SHP_ACK_PULSES   2
`define SHP_PTR_CMD      3'h0
`define SHP_PTR_INT      3'h1
`define SHP_PTR_VEC      3'h2
`define SHP_PTR_RXCTL    3'h3
`define SHP_PTR_TXCTL    3'h5
`define SHP_CMD_CHRESET  3'h3
`define SHP_BIT_TXIE     1
`define SHP_BIT_RXIE     3
`define SHP_BIT_WAITRX   5
`define SHP_BIT_WAITEN   7
`define SHP_BIT_VECEN    0
`define SHP_BIT_RXEN     0
`define SHP_BIT_TXEN     3
`define SHP_BIT_RTS      1
`define SHP_BIT_DTR      7
`define SHP_VEC_RESET    8'h00
`endif

// ===== shared/shp_pkg.sv
// Purpose: types of the serial controller host port
// Assumes: nothing
// Notes: acknowledge states are gray coded
package shp_pkg;
    typedef enum logic [1:0] {
        SHP_ACK_IDLE = 2'b00,
        SHP_ACK_MID  = 2'b01,
        SHP_ACK_LAST = 2'b11
    } shp_ack_state_type;
endpackage : shp_pkg

// ===== rtl/shp_fifo.sv
// Purpose: small byte buffer for one direction of one channel
// Assumes: push ignored when full, pop ignored when empty
// Notes: flush empties it in one cycle
`timescale 1ns/10ps
`default_nettype none
module shp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             flush,
    input  wire logic             push,
    input  wire logic [WIDTH-1:0] din,
    input  wire logic             pop,
    output logic      [WIDTH-1:0] dout,
    output logic                  full,
    output logic                  empty
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    rp_q;
    logic [AW:0]      cnt_q;
    logic             do_push;
    logic             do_pop;

    function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
        nxt = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : nxt

    assign full    = (cnt_q == (AW+1)'(DEPTH));
    assign empty   = (cnt_q == '0);
    assign do_push = push && !full;
    assign do_pop  = pop && !empty;
    assign dout    = mem_q[rp_q];

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem_q[wp_q] <= din;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn || flush) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (do_push) wp_q <= nxt(wp_q);
            if (do_pop)  rp_q <= nxt(rp_q);
            cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule : shp_fifo
`default_nettype wire

// ===== rtl/shp_host_port.sv
// Purpose: host bus port of a two-channel serial controller
// Assumes: all inputs synchronous to clk; serial engines sit outside
// Notes: strobes and chip select active low, chan_sel and ctl_sel active high; outputs are registered
`timescale 1ns/10ps
`default_nettype none
`include "shp_consts.svh"
module shp_host_port
    import shp_pkg::*;
#(
    parameter int ACK_PULSES = `SHP_ACK_PULSES,
    parameter int TX_DEPTH   = `SHP_TX_DEPTH,
    parameter int RX_DEPTH   = `SHP_RX_DEPTH
) (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       cs_n,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic       chan_sel,
    input  wire logic       ctl_sel,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe,
    input  wire logic       dma_grant_in_n,
    input  wire logic       vector_acknowledge_strobe_n,
    input  wire logic       chain_grant_in_n,
    output logic            chain_grant_out_n,
    output logic            int_n,
    output logic            stall_out_a_n,
    output logic            stall_out_b_n,
    input  wire logic       tx_line_a,
    input  wire logic       tx_line_b,
    output logic            serial_out_a,
    output logic            serial_out_b,
    output logic            terminal_ready_a,
    output logic            terminal_ready_b,
    output logic            send_request_a,
    output logic            send_request_b,
    input  wire logic       tx_pop_a,
    input  wire logic       tx_pop_b,
    output logic      [7:0] tx_byte_a,
    output logic      [7:0] tx_byte_b,
    output logic            tx_ready_a,
    output logic            tx_ready_b,
    input  wire logic       rx_push_a,
    input  wire logic       rx_push_b,
    input  wire logic [7:0] rx_byte_a,
    input  wire logic [7:0] rx_byte_b
);
    logic [2:0]        ptr_q [2];
    logic [7:0]        cr1_q [2];
    logic [1:0]        rx_en_q;
    logic [1:0]        tx_en_q;
    logic              vec_en_q;
    logic [7:0]        vector_q;
    logic              rd_q;
    logic              wr_q;
    logic              wr_ch_q;
    logic              wr_ctl_q;
    logic              rd_ch_q;
    logic              rd_ctl_q;
    logic [7:0]        wr_data_q;
    logic [1:0]        flush_q;
    shp_ack_state_type ack_q;
    logic              respond_q;
    logic              vack_q;
    logic [1:0]        tx_full;
    logic [1:0]        tx_empty;
    logic [1:0]        rx_empty;
    logic [7:0]        tx_head [2];
    logic [7:0]        rx_head [2];
    logic [1:0]        tx_push;
    logic [1:0]        rx_pop;
    logic [1:0]        rx_push;
    logic [1:0]        tx_pop;
    logic [7:0]        rx_din [2];
    logic [1:0]        wait_cond;
    logic [1:0]        chan_int;
    logic              dma;
    logic              rd_act;
    logic              wr_act;
    logic              ch;
    logic              ctl;
    logic              rd_end;
    logic              wr_end;
    logic              int_req;
    logic              vack;
    logic              vack_end;
    logic [7:0]        rd_value;

    function automatic logic [7:0] status(input logic c);
        status = {5'h00, tx_empty[c], (c == 1'b0) && int_req, !rx_empty[c]};
    endfunction : status

    assign dma      = !dma_grant_in_n;
    assign rd_act   = !rd_n && (!cs_n || dma);
    assign wr_act   = !wr_n && (!cs_n || dma);
    // dma serves channel A first, then B
    assign ch       = dma ? (rd_act ? rx_empty[0] : tx_full[0]) : chan_sel;
    assign ctl      = dma ? 1'b0 : ctl_sel;
    assign rd_end   = rd_q && !rd_act;
    assign wr_end   = wr_q && !wr_act;
    assign vack     = !vector_acknowledge_strobe_n;
    assign vack_end = vack_q && !vack;
    assign rx_push  = {rx_push_b && rx_en_q[1], rx_push_a && rx_en_q[0]};
    assign tx_pop   = {tx_pop_b, tx_pop_a};
    assign rx_din[0] = rx_byte_a;
    assign rx_din[1] = rx_byte_b;

    always_comb begin
        for (int c = 0; c < 2; c++) begin
            tx_push[c]  = wr_end && !wr_ctl_q && (wr_ch_q == c[0]);
            rx_pop[c]   = rd_end && !rd_ctl_q && (rd_ch_q == c[0]);
            chan_int[c] = (cr1_q[c][`SHP_BIT_RXIE] && !rx_empty[c])
                       || (cr1_q[c][`SHP_BIT_TXIE] && tx_empty[c] && tx_en_q[c]);
            // stall follows one side only, chosen per channel
            wait_cond[c] = cr1_q[c][`SHP_BIT_WAITEN] && !ctl && (ch == c[0])
                && (cr1_q[c][`SHP_BIT_WAITRX] ? (rd_act && rx_empty[c])
                                              : (wr_act && tx_full[c]));
        end
    end
    assign int_req = |chan_int;

    always_comb begin
        if (ctl) begin
            case (ptr_q[ch])
                `SHP_PTR_CMD: rd_value = status(ch);
                `SHP_PTR_VEC: rd_value = ch ? vector_q : 8'h00;
                default:      rd_value = 8'h00;
            endcase
        end else begin
            rd_value = rx_head[ch];
        end
    end

    for (genvar g = 0; g < 2; g++) begin : g_chan
        shp_fifo #(.WIDTH(8), .DEPTH(TX_DEPTH)) u_tx (
            .clk    (clk),
            .resetn (resetn),
            .flush  (flush_q[g]),
            .push   (tx_push[g]),
            .din    (wr_data_q),
            .pop    (tx_pop[g]),
            .dout   (tx_head[g]),
            .full   (tx_full[g]),
            .empty  (tx_empty[g])
        );
        shp_fifo #(.WIDTH(8), .DEPTH(RX_DEPTH)) u_rx (
            .clk    (clk),
            .resetn (resetn),
            .flush  (flush_q[g]),
            .push   (rx_push[g]),
            .din    (rx_din[g]),
            .pop    (rx_pop[g]),
            .dout   (rx_head[g]),
            .full   (),
            .empty  (rx_empty[g])
        );
    end

    // access tracking: load the access fields while a strobe is active, hold them once it ends
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rd_q      <= 1'b0;
            wr_q      <= 1'b0;
            wr_ch_q   <= 1'b0;
            wr_ctl_q  <= 1'b0;
            rd_ch_q   <= 1'b0;
            rd_ctl_q  <= 1'b0;
            wr_data_q <= 8'h00;
        end else begin
            rd_q <= rd_act;
            wr_q <= wr_act;
            if (wr_act) begin
                wr_ch_q   <= ch;
                wr_ctl_q  <= ctl;
                wr_data_q <= data_in;
            end
            if (rd_act) begin
                rd_ch_q  <= ch;
                rd_ctl_q <= ctl;
            end
        end
    end

    // control register writes through the per-channel pointer
    always_ff @(posedge clk) begin
        if (!resetn) begin
            for (int c = 0; c < 2; c++) begin
                ptr_q[c] <= `SHP_PTR_CMD;
                cr1_q[c] <= 8'h00;
            end
            rx_en_q  <= 2'b00;
            tx_en_q  <= 2'b00;
            flush_q  <= 2'b00;
            vec_en_q <= 1'b0;
            vector_q <= `SHP_VEC_RESET;
        end else begin
            flush_q <= 2'b00;
            if (wr_end && wr_ctl_q) begin
                if (ptr_q[wr_ch_q] == `SHP_PTR_CMD) begin
                    ptr_q[wr_ch_q] <= wr_data_q[2:0];
                    if (wr_data_q[5:3] == `SHP_CMD_CHRESET) begin
                        flush_q[wr_ch_q] <= 1'b1;
                        cr1_q[wr_ch_q]   <= 8'h00;
                        rx_en_q[wr_ch_q] <= 1'b0;
                        tx_en_q[wr_ch_q] <= 1'b0;
                    end
                end else begin
                    ptr_q[wr_ch_q] <= `SHP_PTR_CMD;
                    case (ptr_q[wr_ch_q])
                        `SHP_PTR_INT:   cr1_q[wr_ch_q] <= wr_data_q;
                        `SHP_PTR_VEC: begin
                            if (wr_ch_q) vector_q <= wr_data_q;
                            else         vec_en_q <= wr_data_q[`SHP_BIT_VECEN];
                        end
                        `SHP_PTR_RXCTL: rx_en_q[wr_ch_q] <= wr_data_q[`SHP_BIT_RXEN];
                        `SHP_PTR_TXCTL: tx_en_q[wr_ch_q] <= wr_data_q[`SHP_BIT_TXEN];
                        default: ;
                    endcase
                end
            end else if (rd_end && rd_ctl_q) begin
                ptr_q[rd_ch_q] <= `SHP_PTR_CMD;
            end
        end
    end

    // modem and serial line outputs
    always_ff @(posedge clk) begin
        if (!resetn) begin
            terminal_ready_a <= 1'b1;
            terminal_ready_b <= 1'b1;
            send_request_a   <= 1'b1;
            send_request_b   <= 1'b1;
            serial_out_a     <= 1'b1;
            serial_out_b     <= 1'b1;
        end else begin
            serial_out_a <= tx_en_q[0] ? tx_line_a : 1'b1;
            serial_out_b <= tx_en_q[1] ? tx_line_b : 1'b1;
            if (wr_end && wr_ctl_q && ptr_q[wr_ch_q] == `SHP_PTR_TXCTL) begin
                if (wr_ch_q) begin
                    terminal_ready_b <= !wr_data_q[`SHP_BIT_DTR];
                    send_request_b   <= !wr_data_q[`SHP_BIT_RTS];
                end else begin
                    terminal_ready_a <= !wr_data_q[`SHP_BIT_DTR];
                    send_request_a   <= !wr_data_q[`SHP_BIT_RTS];
                end
            end
        end
    end

    // engine-facing transmit outputs
    always_ff @(posedge clk) begin
        if (!resetn) begin
            tx_byte_a  <= 8'h00;
            tx_byte_b  <= 8'h00;
            tx_ready_a <= 1'b0;
            tx_ready_b <= 1'b0;
        end else begin
            tx_byte_a  <= tx_head[0];
            tx_byte_b  <= tx_head[1];
            tx_ready_a <= tx_en_q[0] && !tx_empty[0] && !tx_pop_a;
            tx_ready_b <= tx_en_q[1] && !tx_empty[1] && !tx_pop_b;
        end
    end

    // acknowledge sequence
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ack_q     <= SHP_ACK_IDLE;
            respond_q <= 1'b0;
            vack_q    <= 1'b0;
        end else begin
            vack_q <= vack;
            if (vack && !vack_q && ack_q == SHP_ACK_IDLE) begin
                respond_q <= !chain_grant_in_n && int_req && vec_en_q;
            end
            if (vack_end) begin
                case (ack_q)
                    SHP_ACK_IDLE: ack_q <= (ACK_PULSES > 2) ? SHP_ACK_MID : SHP_ACK_LAST;
                    SHP_ACK_MID:  ack_q <= SHP_ACK_LAST;
                    SHP_ACK_LAST: ack_q <= SHP_ACK_IDLE;
                    default:      ack_q <= SHP_ACK_IDLE;
                endcase
            end
        end
    end

    // data bus, interrupt, chain and stall outputs
    always_ff @(posedge clk) begin
        if (!resetn) begin
            data_out          <= 8'h00;
            data_oe           <= 1'b0;
            int_n             <= 1'b1;
            chain_grant_out_n <= 1'b1;
            stall_out_a_n     <= 1'b1;
            stall_out_b_n     <= 1'b1;
        end else begin
            if (vack && ack_q == SHP_ACK_LAST && respond_q) begin
                data_out <= vector_q;
                data_oe  <= 1'b1;
            end else begin
                data_out <= rd_value;
                data_oe  <= rd_act;
            end
            int_n             <= !int_req;
            chain_grant_out_n <= !(!chain_grant_in_n && !int_req);
            stall_out_a_n     <= !wait_cond[0];
            stall_out_b_n     <= !wait_cond[1];
        end
    end

    property p_oe_sel;
        @(posedge clk) disable iff (!resetn)
        (data_oe && !$past(vack)) |-> $past(rd_act);
    endproperty
    a_oe_sel: assert property (p_oe_sel) else $error("bus driven without read");

    property p_dtr_write;
        @(posedge clk) disable iff (!resetn)
        (wr_end && wr_ctl_q && !wr_ch_q && ptr_q[0] == `SHP_PTR_TXCTL)
        |=> terminal_ready_a == !$past(wr_data_q[`SHP_BIT_DTR]);
    endproperty
    a_dtr_write: assert property (p_dtr_write) else $error("control write lost");

    property p_chan_b;
        @(posedge clk) disable iff (!resetn)
        (!cs_n && !dma && !wr_n && chan_sel && !ctl_sel && !tx_full[1]) ##1 wr_end
        |=> !tx_empty[1];
    endproperty
    a_chan_b: assert property (p_chan_b) else $error("channel B write missed");

    property p_ctl_nopop;
        @(posedge clk) disable iff (!resetn)
        (rd_end && rd_ctl_q) |-> rx_pop == 2'b00;
    endproperty
    a_ctl_nopop: assert property (p_ctl_nopop) else $error("status read popped data");

    property p_dma_read;
        @(posedge clk) disable iff (!resetn)
        (dma && !rd_n && !rx_empty[0]) |=> (data_oe && data_out == $past(rx_head[0]));
    endproperty
    a_dma_read: assert property (p_dma_read) else $error("dma read gave wrong data");

    property p_reset_out;
        @(posedge clk)
        !resetn |=> (serial_out_a && serial_out_b && terminal_ready_a && send_request_b && int_n);
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("reset outputs wrong");

    property p_int;
        @(posedge clk) disable iff (!resetn)
        int_req [*2] |-> !int_n;
    endproperty
    a_int: assert property (p_int) else $error("interrupt not raised");

    property p_chain;
        @(posedge clk) disable iff (!resetn)
        !chain_grant_out_n |-> ($past(!chain_grant_in_n) && !$past(int_req));
    endproperty
    a_chain: assert property (p_chain) else $error("chain passed with request");

    property p_stall;
        @(posedge clk) disable iff (!resetn)
        (wait_cond[0] ##1 wait_cond[0]) |-> !stall_out_a_n;
    endproperty
    a_stall: assert property (p_stall) else $error("stall missing");

    property p_vector;
        @(posedge clk) disable iff (!resetn)
        (vack && ack_q == SHP_ACK_LAST && respond_q) |=> (data_oe && data_out == $past(vector_q));
    endproperty
    a_vector: assert property (p_vector) else $error("vector not driven");

    c_write: cover property (@(posedge clk) disable iff (!resetn) tx_push[0]);
    c_read:  cover property (@(posedge clk) disable iff (!resetn) rx_pop[1]);
    c_vec:   cover property (@(posedge clk) disable iff (!resetn) vack && respond_q && ack_q == SHP_ACK_LAST);
    c_stall: cover property (@(posedge clk) disable iff (!resetn) !stall_out_b_n);
endmodule : shp_host_port
`default_nettype wire

// ===== verification/shp_engine_model.sv
// Purpose: serial engine model on the far side of the host port
// Assumes: clk shared with the port; pops channel A only
// Notes: pop_en lets the bench stall the transmit side
`timescale 1ns/10ps
`default_nettype none
module shp_engine_model (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       pop_en,
    input  wire logic       tx_ready_a,
    input  wire logic [7:0] tx_byte_a,
    output logic            tx_pop_a,
    output logic            tx_pop_b,
    output logic            tx_line_a,
    output logic            tx_line_b,
    output logic            rx_push_a,
    output logic            rx_push_b,
    output logic      [7:0] rx_byte_a,
    output logic      [7:0] rx_byte_b
);
    logic [1:0] gap_q;
    logic [7:0] popped [$];
    assign tx_pop_b  = 1'b0;
    assign tx_line_a = 1'b0;
    assign tx_line_b = 1'b0;
    initial begin
        rx_push_a = 1'b0;
        rx_push_b = 1'b0;
        rx_byte_a = 8'h00;
        rx_byte_b = 8'h00;
    end
    // gap lets head byte and ready settle; at most one pop in five clocks
    always_ff @(posedge clk) begin
        if (!resetn) begin
            tx_pop_a <= 1'b0;
            gap_q    <= 2'h0;
        end else if (tx_pop_a || gap_q != 2'h0) begin
            tx_pop_a <= 1'b0;
            gap_q    <= gap_q + 2'h1;
        end else if (pop_en && tx_ready_a) begin
            tx_pop_a <= 1'b1;
            popped.push_back(tx_byte_a);
        end
    end
    // idle byte lines show the inverse of the last value
    task automatic push(input logic ch, input logic [7:0] d);
        @(posedge clk);
        #1;
        rx_push_a = !ch;
        rx_push_b = ch;
        rx_byte_a = d;
        rx_byte_b = d;
        @(posedge clk);
        #1;
        rx_push_a = 1'b0;
        rx_push_b = 1'b0;
        rx_byte_a = ~d;
        rx_byte_b = ~d;
    endtask : push
endmodule : shp_engine_model
`default_nettype wire

// ===== verification/shp_host_port_tb.sv
// Purpose: self-checking bench of the host port
// Assumes: inputs driven 1 ns after the rising edge
// Notes: one task per scenario
`timescale 1ns/10ps
`default_nettype none
`include "shp_consts.svh"
module shp_host_port_tb;
    logic       clk, resetn, cs_n, rd_n, wr_n, chan_sel, ctl_sel, dma_grant_in_n, pop_en;
    logic       vector_acknowledge_strobe_n, chain_grant_in_n, chain_grant_out_n, int_n, data_oe;
    logic       stall_out_a_n, stall_out_b_n, serial_out_a, serial_out_b, tx_line_a, tx_line_b;
    logic       terminal_ready_a, terminal_ready_b, send_request_a, send_request_b;
    logic       tx_pop_a, tx_pop_b, tx_ready_a, tx_ready_b, rx_push_a, rx_push_b;
    logic [7:0] data_in, data_out, tx_byte_a, tx_byte_b, rx_byte_a, rx_byte_b, q;
    int         failures, total_checks;
    shp_host_port shp_host_port_i (.clk, .resetn, .cs_n, .rd_n, .wr_n, .chan_sel, .ctl_sel, .data_in,
        .data_out, .data_oe, .dma_grant_in_n, .vector_acknowledge_strobe_n, .chain_grant_in_n,
        .chain_grant_out_n, .int_n, .stall_out_a_n, .stall_out_b_n, .tx_line_a, .tx_line_b,
        .serial_out_a, .serial_out_b, .terminal_ready_a, .terminal_ready_b, .send_request_a,
        .send_request_b, .tx_pop_a, .tx_pop_b, .tx_byte_a, .tx_byte_b, .tx_ready_a, .tx_ready_b,
        .rx_push_a, .rx_push_b, .rx_byte_a, .rx_byte_b);
    shp_engine_model shp_engine_model_i (.clk, .resetn, .pop_en, .tx_ready_a, .tx_byte_a, .tx_pop_a,
        .tx_pop_b, .tx_line_a, .tx_line_b, .rx_push_a, .rx_push_b, .rx_byte_a, .rx_byte_b);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_for(ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk({7'h0, s}, {7'h0, v});
    endtask : wait_for
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic acc(input logic w, input logic dma, input logic ch, input logic ctl, input logic [7:0] d);
        step(1);
        cs_n = dma;
        dma_grant_in_n = !dma;
        chan_sel = ch;
        ctl_sel = ctl;
        data_in = d;
        wr_n = !w;
        rd_n = w;
        if (!w) begin
            wait_for(data_oe, 1'b1);
            q = data_out;
        end
        step(1);
        {cs_n, dma_grant_in_n, rd_n, wr_n} = 4'hf;
        data_in = ~d;
        step(2);
        chk({7'h0, data_oe}, 8'h00);
    endtask : acc
    task automatic cw(input logic ch, input logic [2:0] ptr, input logic [7:0] v);
        acc(1'b1, 1'b0, ch, 1'b1, {5'h0, ptr});
        acc(1'b1, 1'b0, ch, 1'b1, v);
    endtask : cw
    task automatic do_reset;
        step(1);
        resetn = 1'b0;
        step(3);
        resetn = 1'b1;
    endtask : do_reset
    task automatic t_reset;
        chk({serial_out_a, serial_out_b, terminal_ready_a, terminal_ready_b, send_request_a,
             send_request_b, int_n, stall_out_a_n}, 8'hff);
        chk({5'h0, data_oe, tx_ready_a, tx_ready_b}, 8'h00);
        $display("test reset done");
    endtask : t_reset
    task automatic t_int_ack;
        chain_grant_in_n = 1'b0;
        cw(1'b0, `SHP_PTR_INT, 8'h02);
        cw(1'b0, `SHP_PTR_VEC, 8'h01);
        cw(1'b1, `SHP_PTR_VEC, 8'h5c);
        cw(1'b0, `SHP_PTR_TXCTL, 8'h08);
        wait_for(int_n, 1'b0);
        chk({6'h0, int_n, chain_grant_out_n}, 8'h01);
        // chain input inactive: no vector on either pulse
        chain_grant_in_n = 1'b1;
        repeat (2) begin
            vector_acknowledge_strobe_n = 1'b0;
            step(2);
            chk({7'h0, data_oe}, 8'h00);
            vector_acknowledge_strobe_n = 1'b1;
            step(1);
        end
        chain_grant_in_n = 1'b0;
        vector_acknowledge_strobe_n = 1'b0;
        step(1);
        vector_acknowledge_strobe_n = 1'b1;
        step(1);
        vector_acknowledge_strobe_n = 1'b0;
        wait_for(data_oe, 1'b1);
        chk(data_out, 8'h5c);
        vector_acknowledge_strobe_n = 1'b1;
        do_reset();
        step(2);
        chk({6'h0, int_n, chain_grant_out_n}, 8'h02);
        chain_grant_in_n = 1'b1;
        $display("test interrupt done");
    endtask : t_int_ack
    task automatic t_tx_stall;
        int n;
        pop_en = 1'b0;
        cw(1'b0, `SHP_PTR_INT, 8'h80);
        cw(1'b0, `SHP_PTR_TXCTL, 8'h8a);
        step(2);
        chk({4'h0, terminal_ready_a, send_request_a, terminal_ready_b, send_request_b}, 8'h03);
        chk({7'h0, serial_out_a}, 8'h00);
        acc(1'b1, 1'b0, 1'b0, 1'b0, 8'h11);
        acc(1'b1, 1'b0, 1'b0, 1'b0, 8'h22);
        chk({7'h0, stall_out_a_n}, 8'h01);
        // selects and strobe held steady while stalled
        step(1);
        {cs_n, wr_n, chan_sel, ctl_sel} = 4'h0;
        data_in = 8'h33;
        wait_for(stall_out_a_n, 1'b0);
        chk({6'h0, stall_out_a_n, stall_out_b_n}, 8'h01);
        pop_en = 1'b1;
        wait_for(stall_out_a_n, 1'b1);
        chk({7'h0, stall_out_a_n}, 8'h01);
        step(1);
        {cs_n, wr_n} = 2'h3;
        // engine frees a slot first, so the dma write lands in channel A
        step(3);
        acc(1'b1, 1'b1, 1'b0, 1'b0, 8'h44);
        n = 0;
        while (shp_engine_model_i.popped.size() < 4 && n < 80) begin
            step(1);
            n++;
        end
        chk(8'(shp_engine_model_i.popped.size()), 8'h04);
        for (int i = 0; i < 4; i++) begin
            chk(shp_engine_model_i.popped[i], 8'(8'h11 * (i + 1)));
        end
        $display("test transmit done");
    endtask : t_tx_stall
    task automatic t_rx;
        cw(1'b1, `SHP_PTR_RXCTL, 8'h01);
        cw(1'b0, `SHP_PTR_RXCTL, 8'h01);
        for (int i = 0; i < 5; i++) begin
            shp_engine_model_i.push(1'b1, 8'(8'h10 + i));
        end
        for (int i = 0; i < 4; i++) begin
            acc(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
            chk(q, 8'(8'h10 + i));
        end
        acc(1'b0, 1'b0, 1'b1, 1'b1, 8'h00);
        chk(q & 8'h05, 8'h04);
        acc(1'b1, 1'b0, 1'b1, 1'b0, 8'h66);
        acc(1'b0, 1'b0, 1'b1, 1'b1, 8'h00);
        chk(q & 8'h05, 8'h00);
        chk(tx_byte_b, 8'h66);
        shp_engine_model_i.push(1'b0, 8'h77);
        shp_engine_model_i.push(1'b1, 8'h5a);
        acc(1'b0, 1'b1, 1'b0, 1'b0, 8'h00);
        chk(q, 8'h77);
        acc(1'b0, 1'b1, 1'b0, 1'b0, 8'h00);
        chk(q, 8'h5a);
        $display("test receive done");
    endtask : t_rx
    initial begin
        {cs_n, rd_n, wr_n, dma_grant_in_n, vector_acknowledge_strobe_n, chain_grant_in_n} = 6'h3f;
        {resetn, chan_sel, ctl_sel, pop_en} = 4'h0;
        data_in = 8'h00;
        step(3);
        resetn = 1'b1;
        t_reset();
        t_int_ack();
        t_tx_stall();
        t_rx();
        give_verdict();
    end
    initial begin
        #(40 * 6000);
        failures++;
        give_verdict();
    end
endmodule : shp_host_port_tb
`default_nettype wire
